// file: design/bie_pkg.sv
/*
 Package of the block interrupt enable controller: register offsets,
 field positions, reset values and the bus response codes.
 Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package bie_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ENABLE_OFS = 8'h00;
   localparam logic [7:0] PENDING_OFS = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

   // ------------------------------------------------------------
   // Enable register fields
   // ------------------------------------------------------------
   localparam int FRAMER_BIT = 0;
   localparam int ALARM_BIT = 1;
   localparam int SLIP_BIT = 2;
   localparam int DATALINK_BIT = 3;
   localparam int ONE_SECOND_BIT = 4;
   localparam int CLOCK_LOSS_BIT = 5;
   localparam int UNUSED_BIT = 6;
   localparam int NATIONAL_BIT = 7;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] ENABLE_WMASK = 8'hbf;

   // ------------------------------------------------------------
   // Interrupt block fields
   // ------------------------------------------------------------
   localparam int EV_IRQ_RISE = 0;
   localparam int EV_BAD_WRITE = 1;
   localparam logic [1:0] IRQ_STATUS_RST = 2'h0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: design/bie_pending.sv
/*
 One pending bit of a functional block: set by a request pulse, cleared
 when that block's source status register is read.
 Assumes request and clear come from logic on the same clock.
*/
`timescale 1ns/1ns
module bie_pending
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic req, // Request pulse from the block
   input wire logic clr, // Source status read pulse
   output logic pend // Pending bit
);

   typedef struct packed
   {
      logic pend;
   } bie_pend_st_t;

   bie_pend_st_t s_r;
   bie_pend_st_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      // Set wins over clear so a request in the clear cycle is kept
      if (clr)
      begin
         s_nxt.pend = 1'b0;
      end
      if (req)
      begin
         s_nxt.pend = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign pend = s_r.pend;

   a_clear_read : assert property (@(posedge aclk)
      disable iff (!aresetn)
      clr && !req |=> !pend) else $error("pending not cleared");

endmodule

// file: design/bie_ctrl.sv
/*
 Block interrupt enable controller of an E1 framer. Holds the block
 enable register, keeps one pending bit per functional block, and gates
 block requests and two source events onto the shared interrupt pin.
 Assumes an AXI4-Lite master on aclk and request pulses synchronous
 to aclk from the functional blocks.
*/
// What this block does
// - Enable bit 7 lets the national-bit block reach the pin only when set.
// - A source reaches the pin only if its own and its block enable are 1.
// - Bit 5 allows the recovered clock loss interrupt only when set.
// - Bit 4 allows the one-second interrupt only when set.
// - Bit 3 lets the data-link block reach the pin only when set.
// - Bit 2 lets the slip buffer block reach the pin only when set.
// - Bit 1 lets the alarm and error block reach the pin only when set.
// - Bit 0 lets the framer block reach the pin only when set.
// - A block pending bit clears when its source status register is read.
`timescale 1ns/1ns
module bie_ctrl
(
   input wire logic aclk, // System clock, 125 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic national_bit_req, // National-bit block request pulse
   input wire logic national_bit_clr, // Its source status was read
   input wire logic datalink_req, // Data-link block request pulse
   input wire logic datalink_clr, // Its source status was read
   input wire logic slip_buffer_req, // Slip buffer block request pulse
   input wire logic slip_buffer_clr, // Its source status was read
   input wire logic alarm_error_req, // Alarm and error block request pulse
   input wire logic alarm_error_clr, // Its source status was read
   input wire logic framer_req, // Framer block request pulse
   input wire logic framer_clr, // Its source status was read
   input wire logic recovered_clock_loss, // Clock loss condition level
   input wire logic one_second_tick, // One-second condition level
   output logic int_pin, // Shared interrupt output, active high
   output logic ctrl_irq // Controller event interrupt, active high
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] enable;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic int_pin;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
   } bie_ctrl_st_t;

   bie_ctrl_st_t s_r;
   bie_ctrl_st_t s_nxt;

   logic [4:0] pend;
   logic [4:0] blk_req;
   logic [4:0] blk_clr;
   logic [4:0] blk_en;
   logic wr_fire;
   logic rd_fire;
   logic wr_bad;
   logic gated;

   assign blk_req = {national_bit_req, datalink_req, slip_buffer_req,
                     alarm_error_req, framer_req};
   assign blk_clr = {national_bit_clr, datalink_clr, slip_buffer_clr,
                     alarm_error_clr, framer_clr};

   // ------------------------------------------------------------
   // Per-block pending bits
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_pend
         bie_pending u_pend
         (
            .aclk(aclk),
            .aresetn(aresetn),
            .req(blk_req[gi]),
            .clr(blk_clr[gi]),
            .pend(pend[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Gating onto the pin
   // ------------------------------------------------------------
   assign blk_en = {s_r.enable[bie_pkg::NATIONAL_BIT],
                    s_r.enable[bie_pkg::DATALINK_BIT],
                    s_r.enable[bie_pkg::SLIP_BIT],
                    s_r.enable[bie_pkg::ALARM_BIT],
                    s_r.enable[bie_pkg::FRAMER_BIT]};

   // Source-level enables of the blocks live in the blocks, so a
   // pending bit already carries them; here only the block gate is added
   assign gated = (|(pend & blk_en))
      | (recovered_clock_loss
         & s_r.enable[bie_pkg::CLOCK_LOSS_BIT])
      | (one_second_tick & s_r.enable[bie_pkg::ONE_SECOND_BIT]);

   // ------------------------------------------------------------
   // Bus handshakes
   // ------------------------------------------------------------
   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
   assign s_axi_arready = !s_r.rvalid;
   assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_bad = s_r.aw_addr != bie_pkg::ENABLE_OFS
      && s_r.aw_addr != bie_pkg::IRQ_MASK_OFS;

   always_comb
   begin
      s_nxt = s_r;
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
      begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_fire)
      begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = wr_bad ? bie_pkg::RESP_SLVERR : bie_pkg::RESP_OKAY;
         if (s_r.w_strb[0] && s_r.aw_addr == bie_pkg::ENABLE_OFS)
         begin
            // Bit 6 is not writable so it stays zero
            s_nxt.enable = s_r.w_data[7:0] & bie_pkg::ENABLE_WMASK;
         end
         if (s_r.w_strb[0] && s_r.aw_addr == bie_pkg::IRQ_MASK_OFS)
         begin
            s_nxt.irq_mask = s_r.w_data[1:0];
         end
      end
      if (s_r.rvalid && s_axi_rready)
      begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_fire)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = bie_pkg::RESP_OKAY;
         s_nxt.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            bie_pkg::ENABLE_OFS: s_nxt.rdata[7:0] = s_r.enable;
            bie_pkg::PENDING_OFS:
            begin
               s_nxt.rdata[4:0] = pend;
               s_nxt.rdata[5] = recovered_clock_loss;
               s_nxt.rdata[6] = one_second_tick;
            end
            bie_pkg::IRQ_STATUS_OFS:
            begin
               s_nxt.rdata[1:0] = s_r.irq_status;
               s_nxt.irq_status = 2'h0;
            end
            bie_pkg::IRQ_MASK_OFS: s_nxt.rdata[1:0] = s_r.irq_mask;
            default: s_nxt.rresp = bie_pkg::RESP_SLVERR;
         endcase
      end
      // Events set after the read clear, so set wins
      if (gated && !s_r.int_pin)
      begin
         s_nxt.irq_status[bie_pkg::EV_IRQ_RISE] = 1'b1;
      end
      if (wr_fire && wr_bad)
      begin
         s_nxt.irq_status[bie_pkg::EV_BAD_WRITE] = 1'b1;
      end
      // Registered pin adds one cycle but avoids glitches off-chip
      s_nxt.int_pin = gated;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r <= '0;
         s_r.enable <= bie_pkg::ENABLE_RST;
         s_r.irq_status <= bie_pkg::IRQ_STATUS_RST;
         s_r.irq_mask <= bie_pkg::IRQ_MASK_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign int_pin = s_r.int_pin;
   assign ctrl_irq = |(s_r.irq_status & s_r.irq_mask);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_national_gate : assert property (@(posedge aclk)
      disable iff (!aresetn)
      !s_r.enable[7] && !(|pend[3:0]) && !recovered_clock_loss
      && !one_second_tick |=> !int_pin) else $error("national leak");
   a_block_gate : assert property (@(posedge aclk)
      disable iff (!aresetn)
      (|(pend & blk_en)) |=> int_pin) else $error("pin not raised");
   a_pin_quiet : assert property (@(posedge aclk)
      disable iff (!aresetn)
      !gated |=> !int_pin) else $error("pin raised without cause");
   a_clock_loss : assert property (@(posedge aclk)
      disable iff (!aresetn)
      recovered_clock_loss && s_r.enable[5] |=> int_pin)
      else $error("clock loss lost");
   // A source that is off must not hold the pin up on its own
   a_clock_loss_off : assert property (@(posedge aclk)
      disable iff (!aresetn)
      recovered_clock_loss && !s_r.enable[5] && !(|(pend & blk_en))
      && !(one_second_tick && s_r.enable[4]) |=> !int_pin)
      else $error("clock loss leak");
   a_one_second : assert property (@(posedge aclk)
      disable iff (!aresetn)
      one_second_tick && !s_r.enable[4] && !(|(pend & blk_en))
      && !(recovered_clock_loss && s_r.enable[5]) |=> !int_pin)
      else $error("one second leak");
   a_one_second_on : assert property (@(posedge aclk)
      disable iff (!aresetn)
      one_second_tick && s_r.enable[4] |=> int_pin)
      else $error("one second lost");
   a_datalink_gate : assert property (@(posedge aclk)
      disable iff (!aresetn)
      pend[3] && s_r.enable[3] |=> int_pin)
      else $error("datalink lost");
   a_slip_gate : assert property (@(posedge aclk)
      disable iff (!aresetn)
      pend[2] && s_r.enable[2] |=> int_pin) else $error("slip lost");
   a_alarm_gate : assert property (@(posedge aclk)
      disable iff (!aresetn)
      pend[1] && s_r.enable[1] |=> int_pin) else $error("alarm lost");
   a_framer_gate : assert property (@(posedge aclk)
      disable iff (!aresetn)
      pend[0] && s_r.enable[0] |=> int_pin) else $error("framer lost");
   a_bit6_zero : assert property (@(posedge aclk)
      disable iff (!aresetn)
      !s_r.enable[bie_pkg::UNUSED_BIT]) else $error("bit 6 set");
   a_reset_off : assert property (@(posedge aclk)
      !aresetn |=> s_r.enable == 8'h00) else $error("enable not reset");
   a_reset_quiet : assert property (@(posedge aclk)
      !aresetn |=> !int_pin && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs busy after reset");

   // ------------------------------------------------------------
   // Bus and controller status checks
   // ------------------------------------------------------------
   // A response must stand until the master takes it
   a_bvalid_hold : assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rvalid_hold : assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped");
   a_write_answer : assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid) else $error("write not answered");
   a_read_answer : assert property (@(posedge aclk)
      disable iff (!aresetn)
      rd_fire |=> s_axi_rvalid) else $error("read not answered");
   // No new item may be taken while an answer is still waiting
   a_busy_refuse : assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_read_refuse : assert property (@(posedge aclk)
      disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   a_write_lands : assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_fire && s_r.w_strb[0] && s_r.aw_addr == bie_pkg::ENABLE_OFS
      |=> s_r.enable == ($past(s_r.w_data[7:0]) & bie_pkg::ENABLE_WMASK))
      else $error("enable write lost");
   a_strobe_off : assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_fire && !s_r.w_strb[0] |=> s_r.enable == $past(s_r.enable))
      else $error("enable changed without strobe");
   a_bad_write : assert property (@(posedge aclk)
      disable iff (!aresetn)
      wr_fire && wr_bad |=> s_axi_bresp == bie_pkg::RESP_SLVERR
      && s_r.irq_status[bie_pkg::EV_BAD_WRITE]
      && s_r.enable == $past(s_r.enable)) else $error("bad write taken");
   a_rise_status : assert property (@(posedge aclk)
      disable iff (!aresetn)
      gated && !s_r.int_pin |=> s_r.irq_status[bie_pkg::EV_IRQ_RISE])
      else $error("pin rise not recorded");
   // Set wins, so only a read without a new bad write must clear
   a_status_clear : assert property (@(posedge aclk)
      disable iff (!aresetn)
      rd_fire && s_axi_araddr == bie_pkg::IRQ_STATUS_OFS
      && !(wr_fire && wr_bad) |=> !s_r.irq_status[bie_pkg::EV_BAD_WRITE])
      else $error("status not cleared by read");
   a_read_unmapped : assert property (@(posedge aclk)
      disable iff (!aresetn)
      rd_fire && s_axi_araddr != bie_pkg::ENABLE_OFS
      && s_axi_araddr != bie_pkg::PENDING_OFS
      && s_axi_araddr != bie_pkg::IRQ_STATUS_OFS
      && s_axi_araddr != bie_pkg::IRQ_MASK_OFS
      |=> s_axi_rresp == bie_pkg::RESP_SLVERR
      && s_axi_rdata == 32'h0000_0000) else $error("unmapped read taken");

   c_enable_write : cover property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && !wr_bad);
   c_pin_high : cover property (@(posedge aclk) disable iff (!aresetn)
      $rose(int_pin));
   c_pend_clear : cover property (@(posedge aclk) disable iff (!aresetn)
      $fell(pend[0]));
   c_ctrl_irq : cover property (@(posedge aclk) disable iff (!aresetn)
      ctrl_irq);
   c_bad_write : cover property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && wr_bad);

endmodule

// file: tb/bie_ctrl_tb.sv
/*
 Self-checking bench of the block interrupt enable controller.
 Assumes the design package and bie_ctrl; drives all ports itself.
*/
`timescale 1ns/1ns
module bie_ctrl_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, int_pin, ctrl_irq;
   logic [4:0] req_v, clr_v;
   logic cl, os;
   logic [31:0] d;
   logic [1:0] r;
   logic [7:0] en;
   logic [7:0] corner [4] = '{8'h00, 8'h40, 8'hff, 8'h7f};
   logic [4:0] rq_corner [4] = '{5'h1f, 5'h1f, 5'h1f, 5'h10};
   logic [3:0] wstrb;
   int num_errors = 0, n_compared = 0, cyc = 0;

   bie_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .national_bit_req(req_v[4]),
      .national_bit_clr(clr_v[4]), .datalink_req(req_v[3]),
      .datalink_clr(clr_v[3]), .slip_buffer_req(req_v[2]),
      .slip_buffer_clr(clr_v[2]), .alarm_error_req(req_v[1]),
      .alarm_error_clr(clr_v[1]), .framer_req(req_v[0]),
      .framer_clr(clr_v[0]), .recovered_clock_loss(cl),
      .one_second_tick(os), .int_pin(int_pin), .ctrl_irq(ctrl_irq));

   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // Checks and closing
   // ------------------------------------------------------------
   task automatic conclude();
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   always @(posedge aclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         num_errors++;
         conclude();
      end
   end

   // Block pending bits gated by their enables, plus the two levels
   function automatic logic exp_int(logic [7:0] e, logic [4:0] p,
                                    logic c, logic o);
      return |(p & {e[7], e[3:0]}) | (c & e[5]) | (o & e[4]);
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite master
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
      bit ta, tw, tb, done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         @(posedge aclk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
         begin
            rs = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      bit ta, tr, done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         @(posedge aclk);
         if (ta)
            arvalid <= 1'b0;
         if (tr)
         begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic pulse_clr(input logic [4:0] m);
      @(posedge aclk);
      clr_v <= m;
      @(posedge aclk);
      clr_v <= 5'h00;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [4:0] rq;
      {awvalid, wvalid, bready, arvalid, rready, cl, os} = '0;
      {awaddr, araddr, wdata, req_v, clr_v} = '0;
      wstrb = 4'hf;
      aresetn = 1'b0;
      void'($urandom(32'h626f));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(bie_pkg::ENABLE_OFS, d, r);
      chk(d, 32'h0, "enable after reset");
      chk(int_pin, 1'b0, "pin after reset");
      for (int i = 0; i < 40; i++)
      begin
         en = (i < 4) ? corner[i] : 8'($urandom);
         rq = (i < 4) ? rq_corner[i] : 5'($urandom);
         wr(bie_pkg::ENABLE_OFS, {24'h0, en}, r);
         rd(bie_pkg::ENABLE_OFS, d, r);
         chk(d, {24'h0, en & 8'hbf}, "enable readback");
         @(posedge aclk);
         req_v <= rq;
         cl <= (i < 4) ? (i < 3) : 1'($urandom);
         os <= (i < 4) ? (i < 3) : 1'($urandom);
         @(posedge aclk);
         req_v <= 5'h00;
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         chk(int_pin, exp_int(en, rq, cl, os), "pin gate");
         rd(bie_pkg::PENDING_OFS, d, r);
         chk(d[4:0], rq, "pending set");
         pulse_clr(5'h1f);
         @(posedge aclk);
         cl <= 1'b0;
         os <= 1'b0;
         rd(bie_pkg::PENDING_OFS, d, r);
         chk(d[4:0], 5'h00, "pending cleared");
         @(negedge aclk);
         chk(int_pin, 1'b0, "pin after clear");
      end
      // Controller interrupt: bad write, mask, clear on read
      wr(bie_pkg::ENABLE_OFS, 32'h0, r);
      rd(bie_pkg::IRQ_STATUS_OFS, d, r);
      wr(bie_pkg::IRQ_MASK_OFS, 32'h2, r);
      wr(bie_pkg::PENDING_OFS, 32'hff, r);
      chk(r, bie_pkg::RESP_SLVERR, "bad write resp");
      repeat (2) @(negedge aclk);
      chk(ctrl_irq, 1'b1, "irq raised");
      rd(bie_pkg::IRQ_STATUS_OFS, d, r);
      chk(d[1], 1'b1, "status bad write");
      repeat (2) @(negedge aclk);
      chk(ctrl_irq, 1'b0, "irq cleared");
      wr(bie_pkg::IRQ_MASK_OFS, 32'h0, r);
      wr(bie_pkg::PENDING_OFS, 32'hff, r);
      repeat (2) @(negedge aclk);
      chk(ctrl_irq, 1'b0, "irq masked");
      rd(bie_pkg::ENABLE_OFS, d, r);
      chk(d, 32'h0, "bad write no effect");
      wstrb <= 4'he;
      wr(bie_pkg::ENABLE_OFS, 32'hff, r);
      chk(r, bie_pkg::RESP_OKAY, "strobe off resp");
      rd(bie_pkg::ENABLE_OFS, d, r);
      chk(d, 32'h0, "strobe off no write");
      wstrb <= 4'hf;
      rd(8'h10, d, r);
      chk(d, 32'h0, "unmapped read data");
      chk(r, bie_pkg::RESP_SLVERR, "unmapped read resp");
      conclude();
   end
endmodule
